/* File: hdl/tcp_pkg.sv */
// Functional notes
// R1: Force bits read zero; writing zero does nothing
// R2: Force B copies level B onto pin B
// R3: Force A copies level A onto pin A
// R4: Forced compare never sets the compare flag
// R5: Compare B match clocks level B onto pin B
// R6: Compare A match clocks level A onto pin A
// R7: Capture A edge follows the edge-select bit
// R8: Capture B uses falling edges only, no select
// R9: Match is counter equals compare, per increment
package tcp_pkg;
	// ============================================================
	// Register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STAT = 8'h04;
	localparam logic [7:0] OFS_COUNT = 8'h08;
	localparam logic [7:0] OFS_CMP_A = 8'h0C;
	localparam logic [7:0] OFS_CMP_B = 8'h10;
	localparam logic [7:0] OFS_CAP_A = 8'h14;
	localparam logic [7:0] OFS_CAP_B = 8'h18;
	// ============================================================
	// Control fields
	localparam int CTRL_LEVEL_A = 0;
	localparam int CTRL_LEVEL_B = 1;
	localparam int CTRL_EDGE_A = 2;
	localparam int CTRL_FORCE_A = 3;
	localparam int CTRL_FORCE_B = 4;
	localparam int CTRL_WIDTH = 3;
	localparam logic [2:0] CTRL_RESET = 3'h0;
	// ============================================================
	// Status fields, write one to clear
	localparam int STAT_CMP_A = 0;
	localparam int STAT_CMP_B = 1;
	localparam int STAT_CAP_A = 2;
	localparam int STAT_CAP_B = 3;
	// ============================================================
	// Counter and timing
	localparam int COUNT_WIDTH = 16;
	localparam int PRESCALE = 4;
	localparam logic [15:0] COUNT_RESET = 16'h0000;
	localparam logic [15:0] CMP_RESET = 16'hFFFF;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage

/* File: hdl/tcp_capture.sv */
`timescale 1ns/1ps
module tcp_capture #(
	parameter int WIDTH = 16
) (
	input wire logic clk, // Bus clock
	input wire logic rstn, // Async reset, low
	input wire logic pin, // Capture pin
	input wire logic edge_rise, // 1 rising, 0 falling
	input wire logic [WIDTH-1:0] count, // Free-running counter
	input wire logic flag_clear, // Clear pulse for flag
	output logic [WIDTH-1:0] value, // Captured counter value
	output logic flag // Capture happened
);
	logic pin_reg;
	logic [WIDTH-1:0] value_reg;
	logic flag_reg;
	wire rise = pin & ~pin_reg;
	wire fall = ~pin & pin_reg;
	wire hit = edge_rise ? rise : fall; // see R7
	// ============================================================
	// Edge detect and snapshot
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pin_reg <= 1'b0;
			value_reg <= '0;
			flag_reg <= 1'b0;
		end else begin
			pin_reg <= pin;
			if (hit) begin
				value_reg <= count;
			end
			flag_reg <= hit | (flag_reg & ~flag_clear);
		end
	end
	assign value = value_reg;
	assign flag = flag_reg;
endmodule

/* File: hdl/tcp_compare.sv */
`timescale 1ns/1ps
module tcp_compare #(
	parameter int WIDTH = 16
) (
	input wire logic clk, // Bus clock
	input wire logic rstn, // Async reset, low
	input wire logic tick, // Counter increments now
	input wire logic [WIDTH-1:0] count, // Free-running counter
	input wire logic [WIDTH-1:0] cmp, // Compare value
	input wire logic level, // Level to drive on event
	input wire logic force_pulse, // Forced compare strobe
	input wire logic flag_clear, // Clear pulse for flag
	output logic match, // Genuine compare this cycle
	output logic pin_out, // Compare output pin
	output logic flag // Compare flag
);
	logic out_reg;
	logic flag_reg;
	assign match = tick & (count == cmp); // see R9
	// ============================================================
	// Output level latch and flag
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			out_reg <= 1'b0;
			flag_reg <= 1'b0;
		end else begin
			if (match | force_pulse) begin
				out_reg <= level; // see R5 see R6 see R2 see R3
			end
			flag_reg <= match | (flag_reg & ~flag_clear); // see R4
		end
	end
	assign pin_out = out_reg;
	assign flag = flag_reg;
endmodule

/* File: hdl/tcp_top.sv */
`timescale 1ns/1ps
module tcp_top #(
	parameter int COUNT_WIDTH = tcp_pkg::COUNT_WIDTH,
	parameter int PRESCALE = tcp_pkg::PRESCALE
) (
	input wire logic clk, // 50 MHz bus clock
	input wire logic rstn, // Async reset, low
	input wire logic hsel, // AHB select
	input wire logic [7:0] haddr, // AHB byte address
	input wire logic [1:0] htrans, // AHB transfer type
	input wire logic hwrite, // AHB write
	input wire logic [2:0] hsize, // AHB size
	input wire logic [31:0] hwdata, // AHB write data
	input wire logic hready, // AHB bus ready
	output logic [31:0] hrdata, // AHB read data
	output logic hreadyout, // AHB slave ready
	output logic hresp, // AHB response, always OKAY
	input wire logic capture_in_a, // Capture pin A
	input wire logic capture_in_b, // Capture pin B
	output logic compare_out_a, // Compare pin A
	output logic compare_out_b // Compare pin B
);
	// ============================================================
	// State
	logic [7:0] addr_reg;
	logic wr_pend_reg;
	logic rd_pend_reg;
	logic [31:0] hrdata_reg;
	logic [tcp_pkg::CTRL_WIDTH-1:0] ctrl_reg;
	logic [tcp_pkg::CTRL_WIDTH-1:0] ctrl_next;
	logic [COUNT_WIDTH-1:0] count_reg;
	logic [COUNT_WIDTH-1:0] cmp_a_reg;
	logic [COUNT_WIDTH-1:0] cmp_b_reg;
	logic [$clog2(PRESCALE+1)-1:0] pre_reg;
	logic [COUNT_WIDTH-1:0] cap_a;
	logic [COUNT_WIDTH-1:0] cap_b;
	logic compare_flag_a;
	logic compare_flag_b;
	logic cap_flag_a;
	logic cap_flag_b;
	logic match_a;
	logic match_b;
	logic [31:0] rd_mux;

	// ============================================================
	// Bus decode
	wire addr_phase = hsel & hready & htrans[1];
	wire wr_ctrl = wr_pend_reg & (addr_reg == tcp_pkg::OFS_CTRL);
	wire wr_stat = wr_pend_reg & (addr_reg == tcp_pkg::OFS_STAT);
	wire wr_cmp_a = wr_pend_reg & (addr_reg == tcp_pkg::OFS_CMP_A);
	wire wr_cmp_b = wr_pend_reg & (addr_reg == tcp_pkg::OFS_CMP_B);
	// Writing zero to a force bit does nothing
	wire force_a = wr_ctrl & hwdata[tcp_pkg::CTRL_FORCE_A]; // see R1 see R3
	wire force_b = wr_ctrl & hwdata[tcp_pkg::CTRL_FORCE_B]; // see R1 see R2
	// A write that forces also takes the level it carries
	wire level_a = ctrl_next[tcp_pkg::CTRL_LEVEL_A];
	wire level_b = ctrl_next[tcp_pkg::CTRL_LEVEL_B];
	wire clr_cmp_a = wr_stat & hwdata[tcp_pkg::STAT_CMP_A];
	wire clr_cmp_b = wr_stat & hwdata[tcp_pkg::STAT_CMP_B];
	wire clr_cap_a = wr_stat & hwdata[tcp_pkg::STAT_CAP_A];
	wire clr_cap_b = wr_stat & hwdata[tcp_pkg::STAT_CAP_B];
	wire tick = (pre_reg == ($clog2(PRESCALE+1))'(PRESCALE - 1));
	wire [31:0] ctrl_rd = {29'h0, ctrl_reg}; // see R1
	wire [31:0] stat_rd = {28'h0, cap_flag_b, cap_flag_a, compare_flag_b, compare_flag_a};

	assign ctrl_next = wr_ctrl ? hwdata[tcp_pkg::CTRL_WIDTH-1:0] : ctrl_reg;
	assign rd_mux = (addr_reg == tcp_pkg::OFS_CTRL) ? ctrl_rd :
		(addr_reg == tcp_pkg::OFS_STAT) ? stat_rd :
		(addr_reg == tcp_pkg::OFS_COUNT) ? 32'(count_reg) :
		(addr_reg == tcp_pkg::OFS_CMP_A) ? 32'(cmp_a_reg) :
		(addr_reg == tcp_pkg::OFS_CMP_B) ? 32'(cmp_b_reg) :
		(addr_reg == tcp_pkg::OFS_CAP_A) ? 32'(cap_a) :
		(addr_reg == tcp_pkg::OFS_CAP_B) ? 32'(cap_b) : 32'h0000_0000;
	assign hreadyout = ~rd_pend_reg;
	assign hresp = 1'b0;
	assign hrdata = hrdata_reg;

	// ============================================================
	// AHB slave: writes zero wait, reads one wait state
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			addr_reg <= 8'h00;
			wr_pend_reg <= 1'b0;
			rd_pend_reg <= 1'b0;
			hrdata_reg <= 32'h0000_0000;
		end else begin
			if (hready) begin
				addr_reg <= haddr;
				wr_pend_reg <= addr_phase & hwrite;
			end
			rd_pend_reg <= addr_phase & ~hwrite;
			if (rd_pend_reg) begin
				hrdata_reg <= rd_mux;
			end
		end
	end

	// ============================================================
	// Registers and free-running counter
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ctrl_reg <= tcp_pkg::CTRL_RESET;
			cmp_a_reg <= tcp_pkg::CMP_RESET;
			cmp_b_reg <= tcp_pkg::CMP_RESET;
			count_reg <= tcp_pkg::COUNT_RESET;
			pre_reg <= '0;
		end else begin
			ctrl_reg <= ctrl_next;
			if (wr_cmp_a) begin
				cmp_a_reg <= hwdata[COUNT_WIDTH-1:0];
			end
			if (wr_cmp_b) begin
				cmp_b_reg <= hwdata[COUNT_WIDTH-1:0];
			end
			pre_reg <= tick ? '0 : pre_reg + 1'b1;
			if (tick) begin
				count_reg <= count_reg + 1'b1;
			end
		end
	end

	// ============================================================
	// Channels
	tcp_compare #(.WIDTH(COUNT_WIDTH)) u_cmp_a (
		.clk(clk),
		.rstn(rstn),
		.tick(tick),
		.count(count_reg),
		.cmp(cmp_a_reg),
		.level(level_a),
		.force_pulse(force_a),
		.flag_clear(clr_cmp_a),
		.match(match_a),
		.pin_out(compare_out_a),
		.flag(compare_flag_a)
	);

	tcp_compare #(.WIDTH(COUNT_WIDTH)) u_cmp_b (
		.clk(clk),
		.rstn(rstn),
		.tick(tick),
		.count(count_reg),
		.cmp(cmp_b_reg),
		.level(level_b),
		.force_pulse(force_b),
		.flag_clear(clr_cmp_b),
		.match(match_b),
		.pin_out(compare_out_b),
		.flag(compare_flag_b)
	);

	tcp_capture #(.WIDTH(COUNT_WIDTH)) u_cap_a (
		.clk(clk),
		.rstn(rstn),
		.pin(capture_in_a),
		.edge_rise(ctrl_reg[tcp_pkg::CTRL_EDGE_A]), // see R7
		.count(count_reg),
		.flag_clear(clr_cap_a),
		.value(cap_a),
		.flag(cap_flag_a)
	);

	tcp_capture #(.WIDTH(COUNT_WIDTH)) u_cap_b (
		.clk(clk),
		.rstn(rstn),
		.pin(capture_in_b),
		.edge_rise(1'b0), // see R8
		.count(count_reg),
		.flag_clear(clr_cap_b),
		.value(cap_b),
		.flag(cap_flag_b)
	);

	// ============================================================
	// Assertions
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	a_force_reads_zero: assert property ( // see R1
		$past(rd_pend_reg) && $past(addr_reg) == tcp_pkg::OFS_CTRL |-> hrdata[4:3] == 2'h0
	) else $error("Force bits read as one");

	a_force_b_pin: assert property ( // see R2
		force_b |=> compare_out_b == $past(level_b)
	) else $error("Force B did not set pin B");

	a_force_a_pin: assert property ( // see R3
		force_a |=> compare_out_a == $past(level_a)
	) else $error("Force A did not set pin A");

	a_force_no_flag: assert property ( // see R4
		force_a && !match_a && !compare_flag_a |=> !compare_flag_a
	) else $error("Forced compare set flag A");

	a_match_b_level: assert property ( // see R5
		match_b && !force_b |=> compare_out_b == $past(level_b) && compare_flag_b
	) else $error("Compare B event wrong");

	a_match_a_level: assert property ( // see R6
		match_a && !force_a |=> compare_out_a == $past(level_a) && compare_flag_a
	) else $error("Compare A event wrong");

	a_pin_a_hold: assert property ( // see R6
		!match_a && !force_a |=> $stable(compare_out_a)
	) else $error("Pin A changed without event");

	a_pin_b_hold: assert property ( // see R5
		!match_b && !force_b |=> $stable(compare_out_b)
	) else $error("Pin B changed without event");

	a_force_flag_b: assert property ( // see R4
		force_b && !match_b && !compare_flag_b |=> !compare_flag_b
	) else $error("Forced compare set flag B");

	a_capture_a_edge: assert property ( // see R7
		ctrl_reg[tcp_pkg::CTRL_EDGE_A] && $rose(capture_in_a) && $stable(ctrl_reg)
			|=> cap_a == $past(count_reg) && cap_flag_a
	) else $error("Capture A missed rising edge");

	a_capture_b_fall: assert property ( // see R8
		$rose(capture_in_b) |=> cap_b == $past(cap_b)
	) else $error("Capture B took a rising edge");

	a_flag_cause: assert property ( // see R9
		$rose(compare_flag_a) |-> $past(tick) && $past(count_reg) == $past(cmp_a_reg)
	) else $error("Flag A set without match");

	a_flag_b_cause: assert property ( // see R9
		$rose(compare_flag_b) |-> $past(tick) && $past(count_reg) == $past(cmp_b_reg)
	) else $error("Flag B set without match");

	a_count_step: assert property ( // see R9
		tick |=> count_reg == $past(count_reg) + 1'b1
	) else $error("Counter did not step on tick");

	a_count_hold: assert property ( // see R9
		!tick |=> $stable(count_reg)
	) else $error("Counter moved between ticks");

	a_match_once: assert property ( // see R9
		match_a |=> !match_a
	) else $error("Match A held for two cycles");

	a_capture_a_fall: assert property ( // see R7
		!ctrl_reg[tcp_pkg::CTRL_EDGE_A] && $fell(capture_in_a) |=> cap_a == $past(count_reg) && cap_flag_a
	) else $error("Capture A missed falling edge");

	a_capture_a_skip: assert property ( // see R7
		ctrl_reg[tcp_pkg::CTRL_EDGE_A] && $fell(capture_in_a) |=> cap_a == $past(cap_a)
	) else $error("Capture A took a falling edge");

	a_capture_b_take: assert property ( // see R8
		$fell(capture_in_b) |=> cap_b == $past(count_reg) && cap_flag_b
	) else $error("Capture B missed falling edge");

	a_flag_set_wins: assert property (
		match_a && clr_cmp_a |=> compare_flag_a
	) else $error("Clear beat a compare event");

	a_flag_clear_a: assert property (
		clr_cmp_a && !match_a |=> !compare_flag_a
	) else $error("Flag A not cleared");

	a_flag_clear_b: assert property (
		clr_cmp_b && !match_b |=> !compare_flag_b
	) else $error("Flag B not cleared");

	a_cap_clear_a: assert property (
		clr_cap_a && !$rose(capture_in_a) && !$fell(capture_in_a) |=> !cap_flag_a
	) else $error("Capture flag A not cleared");

	a_cap_clear_b: assert property (
		clr_cap_b && !$fell(capture_in_b) |=> !cap_flag_b
	) else $error("Capture flag B not cleared");

	a_ctrl_write: assert property (
		wr_ctrl |=> ctrl_reg == $past(hwdata[tcp_pkg::CTRL_WIDTH-1:0])
	) else $error("Control write lost");

	a_read_data: assert property (
		$past(rd_pend_reg) |-> hrdata == $past(rd_mux)
	) else $error("Read data not loaded");

	a_upper_zero: assert property (
		$past(rd_pend_reg) |-> hrdata[31:16] == 16'h0000
	) else $error("Upper read bits not zero");

	a_write_no_wait: assert property (
		addr_phase && hwrite |=> hreadyout
	) else $error("Write inserted a wait state");

	a_read_wait: assert property (
		addr_phase && !hwrite |=> !hreadyout ##1 hreadyout
	) else $error("Read wait state wrong");

	c_force_a: cover property (force_a ##1 compare_out_a);
	c_force_b: cover property (force_b ##1 compare_out_b);
	c_match_b: cover property (match_b ##1 compare_flag_b);
	c_capture_a_fall: cover property (!ctrl_reg[tcp_pkg::CTRL_EDGE_A] && $fell(capture_in_a));
	c_capture_b: cover property ($rose(cap_flag_b));
endmodule

/* File: bench/tcp_pin_model.sv */
`timescale 1ns/1ps
// ============================================================
// Far side: drives capture pins, loads compare pins
module tcp_pin_model (
	input wire logic clk, // Bus clock
	input wire logic compare_out_a, // Compare pin A
	input wire logic compare_out_b, // Compare pin B
	output logic capture_in_a, // Capture pin A
	output logic capture_in_b // Capture pin B
);
	initial begin
		capture_in_a = 1'b0;
		capture_in_b = 1'b0;
	end
	// New levels just after an edge, then settle time
	task automatic drive(input logic a, input logic b);
		@(posedge clk);
		capture_in_a <= a;
		capture_in_b <= b;
		repeat (3) @(posedge clk);
	endtask
endmodule

/* File: bench/tcp_top_tb.sv */
`timescale 1ns/1ps
module tcp_top_tb;
	logic clk, rstn, hsel, hwrite, hreadyout, hresp, cap_a, cap_b, cmp_a, cmp_b, la, lb;
	logic [7:0] haddr;
	logic [1:0] htrans;
	logic [31:0] hwdata, hrdata, rdv, rnd;
	logic [31:0] exp_q[$], msk_q[$], got_q[$];
	int fails, cmp_count;
	tcp_top dut_u (.clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .capture_in_a(cap_a), .capture_in_b(cap_b), .compare_out_a(cmp_a),
		.compare_out_b(cmp_b));
	tcp_pin_model pins_u (.clk(clk), .compare_out_a(cmp_a), .compare_out_b(cmp_b),
		.capture_in_a(cap_a), .capture_in_b(cap_b));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// ============================================================
	// Checking and closing
	task automatic report_and_stop;
		$display("comparisons %0d, mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			fails++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task automatic hang;
		fails++;
		$display("unexpected at %0t: wait ran out", $time);
		report_and_stop();
	endtask
	// Oldest note against each finished read or pin sample
	always @(posedge clk) begin
		if (got_q.size() > 0) begin
			chk(got_q.pop_front() & msk_q.pop_front(), exp_q.pop_front());
		end
	end
	// ============================================================
	// Bus master
	task automatic wrdy;
		logic r;
		int n;
		n = 0;
		do begin
			@(negedge clk);
			r = hreadyout;
			rdv = hrdata;
			@(posedge clk);
			n++;
		end while (r !== 1'b1 && n < 50);
		if (r !== 1'b1) hang();
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		wrdy();
		htrans <= 2'h0;
		hwdata <= d;
		wrdy();
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		bus(1'b0, a, 32'h0000_0000);
		// Top bit also carries the response, which must be OKAY
		exp_q.push_back(e & m);
		msk_q.push_back(m | 32'h8000_0000);
		got_q.push_back(rdv | {hresp, 31'h0000_0000});
	endtask
	// ============================================================
	// Pin checks
	task automatic pin_chk(input logic ea, input logic eb);
		@(negedge clk);
		exp_q.push_back(32'({eb, ea}));
		msk_q.push_back(32'h0000_0003);
		got_q.push_back(32'({cmp_b, cmp_a}));
		@(posedge clk);
	endtask
	task automatic wpin(input logic sel, input logic v);
		int k;
		k = 0;
		@(negedge clk);
		while ((sel ? cmp_b : cmp_a) !== v && k < 200) begin
			@(negedge clk);
			k++;
		end
		if (k >= 200) hang();
		@(posedge clk);
	endtask
	// ============================================================
	// Main sequence
	initial begin
		rstn = 1'b0;
		hsel = 1'b0;
		haddr = 8'h00;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h0000_0000;
		fails = 0;
		cmp_count = 0;
		void'($urandom(34723));
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		rd(tcp_pkg::OFS_CTRL, 32'h0000_0000, 32'h0000_001F);
		rd(tcp_pkg::OFS_CMP_A, 32'h0000_FFFF, 32'hFFFF_FFFF);
		rnd = $urandom();
		la = rnd[0];
		lb = rnd[1];
		bus(1'b1, tcp_pkg::OFS_CTRL, 32'h0000_0018 | 32'({~lb, ~la}));
		pin_chk(~la, ~lb);
		rd(tcp_pkg::OFS_CTRL, 32'({~lb, ~la}), 32'h0000_001F);
		rd(tcp_pkg::OFS_STAT, 32'h0000_0000, 32'h0000_0003);
		bus(1'b1, tcp_pkg::OFS_CTRL, 32'({lb, la}));
		pin_chk(~la, ~lb);
		rd(tcp_pkg::OFS_COUNT, 32'h0000_0000, 32'h0000_0000);
		bus(1'b1, tcp_pkg::OFS_CMP_A, rdv + 32'h0000_0006);
		bus(1'b1, tcp_pkg::OFS_CMP_B, rdv + 32'h0000_000A);
		wpin(1'b0, la);
		pin_chk(la, ~lb);
		wpin(1'b1, lb);
		rd(tcp_pkg::OFS_STAT, 32'h0000_0003, 32'h0000_0003);
		bus(1'b1, tcp_pkg::OFS_STAT, 32'h0000_000F);
		bus(1'b1, tcp_pkg::OFS_CTRL, 32'h0000_0004);
		pins_u.drive(1'b1, 1'b1);
		rd(tcp_pkg::OFS_STAT, 32'h0000_0004, 32'h0000_000C);
		bus(1'b1, tcp_pkg::OFS_STAT, 32'h0000_000C);
		pins_u.drive(1'b0, 1'b0);
		rd(tcp_pkg::OFS_STAT, 32'h0000_0008, 32'h0000_000C);
		bus(1'b1, tcp_pkg::OFS_STAT, 32'h0000_000C);
		bus(1'b1, tcp_pkg::OFS_CTRL, 32'h0000_0000);
		pins_u.drive(1'b1, 1'b1);
		rd(tcp_pkg::OFS_STAT, 32'h0000_0000, 32'h0000_000C);
		pins_u.drive(1'b0, 1'b1);
		rd(tcp_pkg::OFS_STAT, 32'h0000_0004, 32'h0000_000C);
		repeat (3) @(posedge clk);
		report_and_stop();
	end
endmodule
